// ### core/asbp_pkg.sv
// Purpose: Shared constants for the async SRAM byte-lane host controller
// Assumes: 25 MHz ref_clk (40 ns period)
// Notes: Timing figures are the slower speed grade, in ns
package asbp_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // Read access time and write overlap width, ns
  localparam int T_READ_NS = 55;
  localparam int T_WRITE_NS = 40;
  localparam int T_RECOVER_NS = 20;
  // Least times round up to whole cycles
  localparam int READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  typedef enum {ASBP_IDLE, ASBP_RD_WAIT, ASBP_WR_PULSE, ASBP_WR_HOLD, ASBP_RECOVER}
    asbp_state_type;
endpackage

// ### core/asbp_timer.sv
// Purpose: Down counter giving phase lengths in ref_clk cycles
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
module asbp_timer
  import asbp_pkg::*;
#(
  parameter int WIDTH = CNT_W
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // Status
  output logic done
);
  logic [WIDTH-1:0] count;

  if (WIDTH < 1)
  begin : g_width_check
    $error("asbp_timer: WIDTH must be at least 1");
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign done = (count == '0);
endmodule // asbp_timer

// ### core/asbp_host.sv
// Purpose: Host controller driving an async 16-bit two-lane static memory
// Assumes: Memory pins are on-board; data input is synchronised here
// Notes: One access at a time; req is taken while the sequencer is idle, also in the first cycle after reset while ready is still low
module asbp_host
  import asbp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // User request side
  input wire logic req,
  input wire logic req_write,
  input wire logic [asbp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [asbp_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  output logic ready,
  output logic rd_valid,
  output logic [asbp_pkg::DATA_W-1:0] rd_data,
  // Memory pins
  output logic [asbp_pkg::ADDR_W-1:0] mem_addr,
  output logic chip_select_n,
  output logic chip_select_p,
  output logic write_n,
  output logic out_drive_n,
  output logic upper_lane_sel_n,
  output logic lower_lane_sel_n,
  output logic [asbp_pkg::DATA_W-1:0] data_out,
  output logic [asbp_pkg::DATA_W-1:0] data_oe,
  input wire logic [asbp_pkg::DATA_W-1:0] data_in
);
  import asbp_pkg::*;

  asbp_state_type state;
  asbp_state_type next_state;
  logic timer_load;
  logic [CNT_W-1:0] timer_value;
  logic timer_done;
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;
  logic [1:0] lanes;

  // Timer must hold every load value; zero-cycle phases would wrap the load
  if (READ_CYC + 2 >= (1 << CNT_W) || WRITE_CYC >= (1 << CNT_W)
      || WRITE_CYC < 1 || RECOVER_CYC < 1)
  begin : g_timer_check
    $error("asbp_host: timer too narrow or phase too short");
  end

  // Lane mask to a 16-bit per-pin enable
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] l);
    lane_mask = {{LANE_W{l[1]}}, {LANE_W{l[0]}}};
  endfunction

  // Lane enable for the coming cycle: request when idle, else the captured one
  function automatic logic lanes_next(input int idx);
    lanes_next = (state == ASBP_IDLE) ? req_lanes[idx] : lanes[idx];
  endfunction

  asbp_timer #(.WIDTH(CNT_W)) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(timer_load),
    .load_value(timer_value),
    .done(timer_done)
  );

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      data_meta <= '0;
      data_sync <= '0;
    end
    else
    begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = '0;
    unique case (state)
      ASBP_IDLE:
        if (req && req_lanes != 2'b00)
        begin
          next_state = req_write ? ASBP_WR_PULSE : ASBP_RD_WAIT;
          timer_load = 1'b1;
          // Extra two cycles cover the data synchroniser
          timer_value = req_write ? CNT_W'(WRITE_CYC - 1) : CNT_W'(READ_CYC + 1);
        end
      ASBP_RD_WAIT:
        if (timer_done)
        begin
          next_state = ASBP_RECOVER;
          timer_load = 1'b1;
          timer_value = CNT_W'(RECOVER_CYC - 1);
        end
      ASBP_WR_PULSE:
        if (timer_done)
          next_state = ASBP_WR_HOLD;
      ASBP_WR_HOLD:
      begin
        next_state = ASBP_RECOVER;
        timer_load = 1'b1;
        timer_value = CNT_W'(RECOVER_CYC - 1);
      end
      ASBP_RECOVER:
        if (timer_done)
          next_state = ASBP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state <= ASBP_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------
  // Address, lanes and write data capture
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mem_addr <= '0;
      lanes <= 2'b00;
      data_out <= '0;
    end
    else if (state == ASBP_IDLE && next_state != ASBP_IDLE)
    begin
      // Address set on the same edge the selects go active
      mem_addr <= req_addr;
      lanes <= req_lanes;
      data_out <= req_wdata;
    end
  end

  // ----------------------------------------
  // Memory control pins
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      // Full levels from reset, deselected
      chip_select_n <= 1'b1;
      chip_select_p <= 1'b0;
      write_n <= 1'b1;
      out_drive_n <= 1'b1;
      upper_lane_sel_n <= 1'b1;
      lower_lane_sel_n <= 1'b1;
      data_oe <= '0;
    end
    else
    begin
      // Selects with address on one edge, chip_select_n low and chip_select_p high; write strobe drops with them in writes
      chip_select_n <= !(next_state == ASBP_RD_WAIT || next_state == ASBP_WR_PULSE
                         || next_state == ASBP_WR_HOLD);
      chip_select_p <= (next_state == ASBP_RD_WAIT || next_state == ASBP_WR_PULSE
                        || next_state == ASBP_WR_HOLD);
      // Write strobe low only in the pulse; high in reads
      write_n <= !(next_state == ASBP_WR_PULSE);
      // Output drive low only for reads, never in writes
      out_drive_n <= !(next_state == ASBP_RD_WAIT);
      upper_lane_sel_n <= !((next_state == ASBP_RD_WAIT || next_state == ASBP_WR_PULSE
                             || next_state == ASBP_WR_HOLD) && lanes_next(1));
      lower_lane_sel_n <= !((next_state == ASBP_RD_WAIT || next_state == ASBP_WR_PULSE
                             || next_state == ASBP_WR_HOLD) && lanes_next(0));
      // Drive only selected lanes through pulse and hold
      data_oe <= (next_state == ASBP_WR_PULSE || next_state == ASBP_WR_HOLD)
                 ? lane_mask(state == ASBP_IDLE ? req_lanes : lanes) : '0;
    end
  end

  // ----------------------------------------
  // User answer
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      ready <= (next_state == ASBP_IDLE);
      rd_valid <= (state == ASBP_RD_WAIT && timer_done);
      // Unselected lane reads zero
      if (state == ASBP_RD_WAIT && timer_done)
        rd_data <= data_sync & lane_mask(lanes);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_no_bus_fight: assert property (@(posedge ref_clk) disable iff (rst)
    (data_oe != '0) |-> out_drive_n)
    else $error("host drives data while memory output enabled");
  chk_write_strobe_read: assert property (@(posedge ref_clk) disable iff (rst)
    !out_drive_n |-> write_n)
    else $error("write strobe low during read");
  chk_write_overlap: assert property (@(posedge ref_clk) disable iff (rst)
    !write_n |-> (!chip_select_n && chip_select_p
                  && !(upper_lane_sel_n && lower_lane_sel_n)))
    else $error("write strobe outside select overlap");
  chk_data_hold: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(write_n) |-> (data_oe != '0) && !chip_select_n)
    else $error("data or select dropped with write end");
  chk_addr_stable: assert property (@(posedge ref_clk) disable iff (rst)
    (!chip_select_n && !$past(chip_select_n)) |-> $stable(mem_addr))
    else $error("address moved during selected access");
  chk_selects_pair: assert property (@(posedge ref_clk) disable iff (rst)
    chip_select_n == !chip_select_p)
    else $error("chip selects not complementary");
  chk_write_width: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(write_n) |-> !write_n [*1] ##1 write_n)
    else $error("write pulse width wrong");
  chk_lane_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (data_oe != '0) |-> data_oe == lane_mask({!upper_lane_sel_n, !lower_lane_sel_n}))
    else $error("driven lanes differ from selected lanes");
  chk_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(out_drive_n) |-> ##4 rd_valid)
    else $error("read answer late");
endmodule // asbp_host

// ### dv/asbp_sram_model.sv
// Purpose: Behavioural two-lane static memory facing asbp_host
// Assumes: No pull on data lines
// Notes: Released lanes show a toggling pattern
module asbp_sram_model
  import asbp_pkg::*;
(
  // Pattern clock
  input wire logic ref_clk,
  // Memory pins
  input wire logic [asbp_pkg::ADDR_W-1:0] mem_addr,
  input wire logic chip_select_n,
  input wire logic chip_select_p,
  input wire logic write_n,
  input wire logic out_drive_n,
  input wire logic upper_lane_sel_n,
  input wire logic lower_lane_sel_n,
  input wire logic [asbp_pkg::DATA_W-1:0] data_out,
  input wire logic [asbp_pkg::DATA_W-1:0] data_oe,
  output logic [asbp_pkg::DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] lanes, wlanes, wdata, pins;
  logic [DATA_W-1:0] float_pat = 16'h5A3C;
  logic [ADDR_W-1:0] waddr;
  logic sel, wr, rd;
  // ----------------
  // Mode decode
  // ----------------
  assign sel = !chip_select_n && chip_select_p && !(upper_lane_sel_n && lower_lane_sel_n);
  assign lanes = {{8{!upper_lane_sel_n}}, {8{!lower_lane_sel_n}}};
  assign wr = sel && !write_n;
  assign rd = sel && write_n && !out_drive_n;
  // Undriven pins read inverted, so a missing drive corrupts the store
  assign pins = data_out ^ ~data_oe;
  always @(posedge ref_clk) float_pat <= ~float_pat;
  // Decode inline so the capture never races the overlap net
  always @*
  begin
    if (sel && !write_n)
    begin
      waddr = mem_addr;
      wdata = pins;
      wlanes = lanes;
    end
  end
  always @(negedge wr) mem[waddr] = (mem[waddr] & ~wlanes) | (wdata & wlanes);
  always @* data_in = rd ? (mem[mem_addr] & lanes) | (float_pat & ~lanes) : float_pat;
endmodule // asbp_sram_model

// ### dv/test_asbp_host.sv
// Purpose: Self-checking bench for asbp_host
// Assumes: Timing per the hand-over walk
// Notes: Pins judged half a cycle after each edge
module test_asbp_host
  import asbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 19'h00000;
  logic [DATA_W-1:0] req_wdata = 16'h0000;
  logic [1:0] req_lanes = 2'h0;
  logic ready, rd_valid, chip_select_n, chip_select_p, write_n, out_drive_n;
  logic upper_lane_sel_n, lower_lane_sel_n;
  logic [DATA_W-1:0] rd_data, data_out, data_oe, data_in;
  logic [ADDR_W-1:0] mem_addr;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  always #20 ref_clk = ~ref_clk;
  asbp_host dut (.ref_clk, .rst, .req, .req_write, .req_addr, .req_wdata, .req_lanes,
    .ready, .rd_valid, .rd_data, .mem_addr, .chip_select_n, .chip_select_p, .write_n,
    .out_drive_n, .upper_lane_sel_n, .lower_lane_sel_n, .data_out, .data_oe, .data_in);
  asbp_sram_model mem (.ref_clk, .mem_addr, .chip_select_n, .chip_select_p, .write_n,
    .out_drive_n, .upper_lane_sel_n, .lower_lane_sel_n, .data_out, .data_oe, .data_in);
  // ----------------
  // Helpers
  // ----------------
  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [1:0] ln, input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    req <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= ln;
    @(posedge ref_clk);
    req <= 1'b0;
    @(negedge ref_clk);
    check({write_n, out_drive_n, upper_lane_sel_n, lower_lane_sel_n}, {!wr, wr, ~ln});
    check({15'h0000, chip_select_n}, 16'h0000);
    check(mem_addr[15:0], a[15:0]);
    check({13'h0000, mem_addr[18:16]}, {13'h0000, a[18:16]});
    check(data_oe, wr ? {{LANE_W{ln[1]}}, {LANE_W{ln[0]}}} : 16'h0000);
    check(data_out, d);
    if (wr)
    begin
      repeat (WRITE_CYC) @(negedge ref_clk);
      check({data_oe != 16'h0000, chip_select_n, write_n}, 16'h0005);
      repeat (1 + RECOVER_CYC) @(negedge ref_clk);
    end
    else
    begin
      repeat (READ_CYC + 2) @(negedge ref_clk);
      check({ready, rd_valid}, 16'h0001);
      check(rd_data, exp);
      repeat (RECOVER_CYC) @(negedge ref_clk);
    end
    check({ready, rd_valid}, 16'h0002);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic sc_word();
    access(1'b1, 19'h00001, 16'hA55A, 2'h3, 16'h0000);
    access(1'b0, 19'h00001, 16'h0000, 2'h3, 16'hA55A);
  endtask
  task automatic sc_lanes();
    access(1'b1, 19'h00001, 16'h1234, 2'h1, 16'h0000);
    access(1'b1, 19'h00001, 16'hBEEF, 2'h2, 16'h0000);
    access(1'b0, 19'h00001, 16'h0000, 2'h3, 16'hBE34);
    access(1'b0, 19'h00001, 16'h0000, 2'h1, 16'h0034);
    access(1'b0, 19'h00001, 16'h0000, 2'h2, 16'hBE00);
  endtask
  task automatic sc_far_addr();
    access(1'b1, 19'h7FFFF, 16'h0F0F, 2'h3, 16'h0000);
    access(1'b1, 19'h00000, 16'hF0F0, 2'h3, 16'h0000);
    access(1'b0, 19'h7FFFF, 16'h0000, 2'h3, 16'h0F0F);
    access(1'b0, 19'h00000, 16'h0000, 2'h3, 16'hF0F0);
  endtask
  task automatic sc_refused();
    @(posedge ref_clk);
    req <= 1'b1;
    req_lanes <= 2'h0;
    repeat (3) @(posedge ref_clk);
    req <= 1'b0;
    @(negedge ref_clk);
    check({chip_select_n, ready}, 16'h0003);
  endtask
  // Bus-wide watch, every cycle
  always @(negedge ref_clk)
  begin
    check({15'h0000, chip_select_n}, {15'h0000, ~chip_select_p});
    if (out_drive_n === 1'b0)
    begin
      check(data_oe, 16'h0000);
      check({15'h0000, write_n}, 16'h0001);
    end
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    repeat (11) @(posedge ref_clk);
    @(negedge ref_clk);
    check({ready, chip_select_n, write_n, out_drive_n}, 16'h0007);
    check(data_oe, 16'h0000);
    @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    sc_word();
    sc_lanes();
    sc_far_addr();
    sc_refused();
    summarize();
  end
endmodule // test_asbp_host
